// [common/irq_prio_pkg.sv]
// Constants for the peripheral interrupt enable and priority bank.
// Assumes an 8-bit register port with 12-bit byte addresses.
//
// Summary of operation
// R1: serial enable bits 5 and 7 gate the two serial receive requests.
// R2: serial enable bits 4 and 6 gate the two serial transmit requests.
// R3: serial enable bits 1 and 3 gate the two port collision requests.
// R4: serial enable bits 0 and 2 gate port requests; whole register resets 0.
// R5: timer enable bits 5..0 gate timers 6..1; all reset to 0.
// R6: timer gate enable bits 2..0 gate timer 5, 3, 1 gate events.
// R7: capture/compare enable bit 1 is unit 2, bit 0 unit 1.
// R8: misc enable bits 7,6,5,0: scan, checksum, nonvolatile, waveform; reset 0.
// R9: a priority bit of 1 routes its source high, 0 routes it low.
// R10: priority 0 holds timer0, pin change, ext pins; resets 0x31.
// R11: clock/converter priority bits 7,6,1,0 all reset high.
// R12: voltage/comparator priority bits 7,6,1,0 all reset high.
// R13: serial priority mirrors serial enables; unit 1 high, unit 2 low.
// R14: timer priority bits 5..0 mirror timer enables; all reset high.
// R15: peripheral flags stay set until software clears them.
// R16: a request needs flag and enable both set, routed by priority.

package irq_prio_pkg;

   // -------------------------------------------------
   // register bank geometry
   // -------------------------------------------------
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 8;
   localparam int NUM_REGS = 10;

   // -------------------------------------------------
   // register indices
   // -------------------------------------------------
   localparam int IDX_EN_SERIAL  = 0;
   localparam int IDX_EN_TIMER   = 1;
   localparam int IDX_EN_GATE    = 2;
   localparam int IDX_EN_CAPCOMP = 3;
   localparam int IDX_EN_MISC    = 4;
   localparam int IDX_PR_0       = 5;
   localparam int IDX_PR_1       = 6;
   localparam int IDX_PR_2       = 7;
   localparam int IDX_PR_SERIAL  = 8;
   localparam int IDX_PR_TIMER   = 9;

   // -------------------------------------------------
   // serial enable field masks
   // -------------------------------------------------
   localparam logic [DATA_W-1:0] SERIAL_RX_MASK   = 8'ha0;
   localparam logic [DATA_W-1:0] SERIAL_TX_MASK   = 8'h50;
   localparam logic [DATA_W-1:0] SERIAL_COLL_MASK = 8'h0a;
   localparam logic [DATA_W-1:0] SERIAL_PORT_MASK = 8'h05;

   // -------------------------------------------------
   // byte addresses, writable masks, reset values
   // -------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
      12'hec5, 12'hec6, 12'hec7, 12'hec8, 12'hec9,
      12'heba, 12'hebb, 12'hebc, 12'hebd, 12'hebe};
   localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
      8'hff, 8'h3f, 8'h07, 8'h03, 8'he1,
      8'h37, 8'hc3, 8'hc3, 8'hff, 8'h3f};
   localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h31, 8'hc3, 8'hc3, 8'h33, 8'h3f};

   // read-only status: bit 0 high request, bit 1 low request
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'hea0;
   localparam int STATUS_HIGH_BIT = 0;
   localparam int STATUS_LOW_BIT  = 1;

endpackage : irq_prio_pkg

// [hdl/periph_irq_enable_priority.sv]
// Interrupt enable and priority register bank with request routing.
// Assumes flags and pre-enabled requests come from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module periph_irq_enable_priority (
   input  wire  logic                                sys_clk,
   input  wire  logic                                reset,
   input  wire  logic [irq_prio_pkg::ADDR_W-1:0]     reg_addr,
   input  wire  logic [irq_prio_pkg::DATA_W-1:0]     reg_wdata,
   input  wire  logic                                reg_write,
   input  wire  logic                                reg_read,
   output logic       [irq_prio_pkg::DATA_W-1:0]     reg_rdata,
   input  wire  logic [7:0]                          serial_flags,
   input  wire  logic [5:0]                          timer_flags,
   input  wire  logic [2:0]                          gate_flags,
   input  wire  logic [1:0]                          capcomp_flags,
   input  wire  logic [7:0]                          misc_flags,
   input  wire  logic [7:0]                          group0_req,
   input  wire  logic [7:0]                          group1_req,
   input  wire  logic [7:0]                          group2_req,
   input  wire  logic [2:0]                          gate_prio,
   input  wire  logic [1:0]                          capcomp_prio,
   input  wire  logic [7:0]                          misc_prio,
   output logic                                      irq_high,
   output logic                                      irq_low
);

   // -------------------------------------------------
   // register bank
   // -------------------------------------------------
   logic [irq_prio_pkg::DATA_W-1:0] bank_q [irq_prio_pkg::NUM_REGS];
   logic                            irq_high_q;
   logic                            irq_low_q;
   logic [irq_prio_pkg::DATA_W-1:0] rdata_q;
   logic [irq_prio_pkg::DATA_W-1:0] rdata_d;

   // one flop set per register; unimplemented bits stay zero
   genvar gi;
   generate
      for (gi = 0; gi < irq_prio_pkg::NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               bank_q[gi] <= irq_prio_pkg::REG_RESET[gi];  // R4 R10 R11 R12 R13 R14
            end else if (reg_write &&
                         reg_addr == irq_prio_pkg::REG_OFFSET[gi]) begin
               bank_q[gi] <= reg_wdata & irq_prio_pkg::REG_MASK[gi];  // R1 R2 R3 R5
            end
         end
      end
   endgenerate

   // -------------------------------------------------
   // named views of the bank
   // -------------------------------------------------
   logic [7:0] uart_rx_irq_en;
   logic [7:0] uart_tx_irq_en;
   logic [7:0] sport_collision_irq_en;
   logic [7:0] sport_irq_en;
   logic [7:0] serial_en;
   logic [5:0] timer_en;
   logic [2:0] gate_en;
   logic [1:0] capcomp_en;
   logic [7:0] misc_en;
   logic [7:0] group0_prio;
   logic [7:0] group1_prio;
   logic [7:0] group2_prio;
   logic [7:0] serial_prio;
   logic [5:0] timer_prio;

   // serial layout: rx 7/5, tx 6/4, collision 3/1, port 2/0
   assign serial_en   = bank_q[irq_prio_pkg::IDX_EN_SERIAL];  // R1 R2 R3 R4
   assign uart_rx_irq_en = serial_en & irq_prio_pkg::SERIAL_RX_MASK;  // R1
   assign uart_tx_irq_en = serial_en & irq_prio_pkg::SERIAL_TX_MASK;  // R2
   assign sport_collision_irq_en = serial_en & irq_prio_pkg::SERIAL_COLL_MASK;  // R3
   assign sport_irq_en = serial_en & irq_prio_pkg::SERIAL_PORT_MASK;  // R4
   assign timer_en    = bank_q[irq_prio_pkg::IDX_EN_TIMER][5:0];  // R5
   assign gate_en     = bank_q[irq_prio_pkg::IDX_EN_GATE][2:0];  // R6
   assign capcomp_en  = bank_q[irq_prio_pkg::IDX_EN_CAPCOMP][1:0];  // R7
   assign misc_en     = bank_q[irq_prio_pkg::IDX_EN_MISC];  // R8
   assign group0_prio = bank_q[irq_prio_pkg::IDX_PR_0];  // R10
   assign group1_prio = bank_q[irq_prio_pkg::IDX_PR_1];  // R11
   assign group2_prio = bank_q[irq_prio_pkg::IDX_PR_2];  // R12
   assign serial_prio = bank_q[irq_prio_pkg::IDX_PR_SERIAL];  // R13
   assign timer_prio  = bank_q[irq_prio_pkg::IDX_PR_TIMER][5:0];  // R14

   // -------------------------------------------------
   // request gating and routing
   // -------------------------------------------------
   logic [7:0] serial_act;
   logic [5:0] timer_act;
   logic [2:0] gate_act;
   logic [1:0] capcomp_act;
   logic [7:0] misc_act;
   logic [7:0] g0_act;
   logic [7:0] g1_act;
   logic [7:0] g2_act;
   logic       high_d;
   logic       low_d;

   // flags are levels held by the peripherals until cleared
   assign serial_act  = serial_flags & serial_en;  // R15 R16
   assign timer_act   = timer_flags & timer_en;  // R16
   assign gate_act    = gate_flags & gate_en;  // R16
   assign capcomp_act = capcomp_flags & capcomp_en;  // R16
   assign misc_act    = misc_flags & misc_en &  // R8 R16
                        irq_prio_pkg::REG_MASK[irq_prio_pkg::IDX_EN_MISC];
   // these groups arrive already enabled; only priority applies here
   assign g0_act = group0_req & irq_prio_pkg::REG_MASK[irq_prio_pkg::IDX_PR_0];
   assign g1_act = group1_req & irq_prio_pkg::REG_MASK[irq_prio_pkg::IDX_PR_1];
   assign g2_act = group2_req & irq_prio_pkg::REG_MASK[irq_prio_pkg::IDX_PR_2];

   // high level collects sources whose priority bit is one
   assign high_d = |(serial_act & serial_prio)   // R9 R16
                 | |(timer_act & timer_prio)
                 | |(gate_act & gate_prio)
                 | |(capcomp_act & capcomp_prio)
                 | |(misc_act & misc_prio)
                 | |(g0_act & group0_prio)
                 | |(g1_act & group1_prio)
                 | |(g2_act & group2_prio);

   // low level collects the rest
   assign low_d = |(serial_act & ~serial_prio)  // R9 R16
                | |(timer_act & ~timer_prio)
                | |(gate_act & ~gate_prio)
                | |(capcomp_act & ~capcomp_prio)
                | |(misc_act & ~misc_prio)
                | |(g0_act & ~group0_prio)
                | |(g1_act & ~group1_prio)
                | |(g2_act & ~group2_prio);

   // registered so the core sees glitch-free levels; costs one cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_high_q <= 1'b0;
         irq_low_q  <= 1'b0;
      end else begin
         irq_high_q <= high_d;  // R16
         irq_low_q  <= low_d;  // R16
      end
   end

   assign irq_high = irq_high_q;
   assign irq_low  = irq_low_q;

   // -------------------------------------------------
   // read path
   // -------------------------------------------------
   // unmapped addresses read as zero, never stall
   always_comb begin
      rdata_d = '0;
      for (int i = 0; i < irq_prio_pkg::NUM_REGS; i++) begin
         if (reg_addr == irq_prio_pkg::REG_OFFSET[i]) begin
            rdata_d = bank_q[i];
         end
      end
      if (reg_addr == irq_prio_pkg::STATUS_OFFSET) begin
         rdata_d[irq_prio_pkg::STATUS_HIGH_BIT] = irq_high_q;
         rdata_d[irq_prio_pkg::STATUS_LOW_BIT]  = irq_low_q;
      end
   end

   // data held only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= '0;
      end else if (reg_read) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   chk_serial_write: assert property (  // R1
      @(posedge sys_clk) disable iff (reset)
      reg_write && reg_addr == irq_prio_pkg::REG_OFFSET[irq_prio_pkg::IDX_EN_SERIAL]
      |=> serial_en == $past(reg_wdata))
      else $error("serial enable write lost");

   chk_tx_enable_gate: assert property (  // R2
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[6] && serial_en[6] && serial_prio[6]) |=> irq_high_q)
      else $error("transmit 2 request not raised");

   chk_collision_block: assert property (  // R3
      @(posedge sys_clk) disable iff (reset)
      (serial_en == 8'h00 && timer_en == 6'h00 && gate_en == 3'h0 &&
       capcomp_en == 2'h0 && misc_en == 8'h00 && group0_req == 8'h00 &&
       group1_req == 8'h00 && group2_req == 8'h00)
      |=> !irq_high_q && !irq_low_q)
      else $error("request raised while disabled");

   chk_serial_reset: assert property (  // R4
      @(posedge sys_clk) $fell(reset) |-> serial_en == 8'h00)
      else $error("serial enable reset wrong");

   chk_timer_mask: assert property (  // R5
      @(posedge sys_clk) disable iff (reset)
      reg_write && reg_addr == irq_prio_pkg::REG_OFFSET[irq_prio_pkg::IDX_EN_TIMER]
      |=> bank_q[irq_prio_pkg::IDX_EN_TIMER] == ($past(reg_wdata) & 8'h3f))
      else $error("timer enable write wrong");

   chk_gate_low: assert property (  // R6
      @(posedge sys_clk) disable iff (reset)
      (gate_flags[2] && gate_en[2] && !gate_prio[2]) |=> irq_low_q)
      else $error("gate request not routed low");

   chk_capcomp_mask: assert property (  // R7
      @(posedge sys_clk) disable iff (reset)
      bank_q[irq_prio_pkg::IDX_EN_CAPCOMP][7:2] == 6'h00)
      else $error("capture/compare reserved bits set");

   chk_misc_mask: assert property (  // R8
      @(posedge sys_clk) disable iff (reset)
      reg_write && reg_addr == irq_prio_pkg::REG_OFFSET[irq_prio_pkg::IDX_EN_MISC]
      |=> misc_en == ($past(reg_wdata) & 8'he1))
      else $error("misc enable write wrong");

   chk_timer_route: assert property (  // R9
      @(posedge sys_clk) disable iff (reset)
      (timer_flags[0] && timer_en[0] && !timer_prio[0]) |=> irq_low_q)
      else $error("timer 1 not routed low");

   chk_prio0_reset: assert property (  // R10
      @(posedge sys_clk) $fell(reset) |-> group0_prio == 8'h31)
      else $error("priority 0 reset wrong");

   chk_prio12_reset: assert property (  // R11
      @(posedge sys_clk) $fell(reset) |-> group1_prio == 8'hc3 && group2_prio == 8'hc3)
      else $error("priority 1/2 reset wrong");

   chk_volt_route: assert property (  // R12
      @(posedge sys_clk) disable iff (reset)
      (group2_req[7] && group2_prio[7]) |=> irq_high_q)
      else $error("voltage request not high");

   chk_serprio_reset: assert property (  // R13
      @(posedge sys_clk) $fell(reset) |-> serial_prio == 8'h33 && timer_prio == 6'h3f)
      else $error("serial/timer priority reset wrong");

   chk_timprio_read: assert property (  // R14
      @(posedge sys_clk) disable iff (reset)
      reg_read && !reg_write &&
      reg_addr == irq_prio_pkg::REG_OFFSET[irq_prio_pkg::IDX_PR_TIMER]
      |=> reg_rdata == {2'b00, $past(timer_prio)})
      else $error("timer priority read wrong");

   chk_flag_hold: assert property (  // R15
      @(posedge sys_clk) disable iff (reset)
      (serial_act[0] && serial_prio[0]) [*2] |-> irq_high_q)
      else $error("held flag dropped request");

   chk_read_idle: assert property (  // R16
      @(posedge sys_clk) disable iff (reset)
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

   chk_rx_route_low: assert property (  // R1
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[5] && uart_rx_irq_en[5] && !serial_prio[5]) |=> irq_low_q)
      else $error("receive 1 request not routed low");

   chk_tx_route_high: assert property (  // R2
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[4] && uart_tx_irq_en[4] && serial_prio[4]) |=> irq_high_q)
      else $error("transmit 1 request not routed high");

   chk_coll_route_high: assert property (  // R3
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[3] && sport_collision_irq_en[3] && serial_prio[3]) |=> irq_high_q)
      else $error("collision 2 request not routed high");

   chk_port_route_low: assert property (  // R4
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[2] && sport_irq_en[2] && !serial_prio[2]) |=> irq_low_q)
      else $error("port 2 request not routed low");

   chk_match_route_high: assert property (  // R5
      @(posedge sys_clk) disable iff (reset)
      (timer_flags[5] && timer_en[5] && timer_prio[5]) |=> irq_high_q)
      else $error("timer 6 request not routed high");

   chk_gate_route_high: assert property (  // R6
      @(posedge sys_clk) disable iff (reset)
      (gate_flags[0] && gate_en[0] && gate_prio[0]) |=> irq_high_q)
      else $error("timer 1 gate request not routed high");

   chk_capcomp_route: assert property (  // R7
      @(posedge sys_clk) disable iff (reset)
      (capcomp_flags[1] && capcomp_en[1] && !capcomp_prio[1]) |=> irq_low_q)
      else $error("capture/compare 2 request not routed low");

   chk_misc_route: assert property (  // R8
      @(posedge sys_clk) disable iff (reset)
      (misc_flags[7] && misc_en[7] && misc_prio[7]) |=> irq_high_q)
      else $error("scan request not routed high");

   chk_ext_pin_low: assert property (  // R10
      @(posedge sys_clk) disable iff (reset)
      (group0_req[1] && !group0_prio[1]) |=> irq_low_q)
      else $error("external pin 1 request not routed low");

   chk_clock_route_high: assert property (  // R11
      @(posedge sys_clk) disable iff (reset)
      (group1_req[6] && group1_prio[6]) |=> irq_high_q)
      else $error("clock switch request not routed high");

   chk_comp_route_low: assert property (  // R12
      @(posedge sys_clk) disable iff (reset)
      (group2_req[0] && !group2_prio[0]) |=> irq_low_q)
      else $error("comparator 1 request not routed low");

   chk_unit2_route_low: assert property (  // R13
      @(posedge sys_clk) disable iff (reset)
      (serial_flags[7] && serial_en[7] && !serial_prio[7]) |=> irq_low_q)
      else $error("receive 2 request not routed low");

   chk_timer_prio_high: assert property (  // R14
      @(posedge sys_clk) disable iff (reset)
      (timer_flags[3] && timer_en[3] && timer_prio[3]) |=> irq_high_q)
      else $error("timer 4 request not routed high");

   chk_flag_idle: assert property (  // R16
      @(posedge sys_clk) disable iff (reset)
      (serial_flags == 8'h00 && timer_flags == 6'h00 && gate_flags == 3'h0 &&
       capcomp_flags == 2'h0 && misc_flags == 8'h00 && group0_req == 8'h00 &&
       group1_req == 8'h00 && group2_req == 8'h00)
      |=> !irq_high_q && !irq_low_q)
      else $error("request raised with no source");

   chk_status_read: assert property (  // R16
      @(posedge sys_clk) disable iff (reset)
      reg_read && reg_addr == irq_prio_pkg::STATUS_OFFSET
      |=> reg_rdata == {6'h00, $past(irq_low_q), $past(irq_high_q)})
      else $error("status read wrong");

   chk_reset_quiet: assert property (  // R16
      @(posedge sys_clk) reset |-> !irq_high_q && !irq_low_q && reg_rdata == 8'h00)
      else $error("outputs active during reset");

endmodule : periph_irq_enable_priority

`default_nettype wire

// [tb/periph_flag_model.sv]
// Sticky serial source flags, as the peripherals hold them.
// Assumes event and clear pulses are driven on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module periph_flag_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [7:0] event_pulse,
   input  wire logic [7:0] flag_clear,
   output var  logic [7:0] flags_q
);
   // ---------------------------------
   // sticky flags
   // ---------------------------------
   // an event wins over a clear in the same cycle, so no event is lost
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flags_q <= 8'h00;
      end else begin
         flags_q <= (flags_q & ~flag_clear) | event_pulse;
      end
   end
endmodule // periph_flag_model
`default_nettype wire

// [tb/periph_irq_enable_priority_bench.sv]
// Self-checking bench for the interrupt enable and priority bank.
// Assumes the package offsets; expected values are worked out here.
`timescale 1ns/1ns
`default_nettype none

module periph_irq_enable_priority_bench;
   localparam logic [7:0] RST [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h31, 8'hc3, 8'hc3, 8'h33, 8'h3f};
   localparam logic [7:0] MSK [10] = '{8'hff, 8'h3f, 8'h07, 8'h03, 8'he1,
                                       8'h37, 8'hc3, 8'hc3, 8'hff, 8'h3f};
   logic                            sys_clk, reset, reg_write, reg_read, irq_high, irq_low;
   logic [irq_prio_pkg::ADDR_W-1:0] reg_addr;
   logic [7:0]                      reg_wdata, reg_rdata, serial_flags, misc_flags, misc_prio;
   logic [7:0]                      group0_req, group1_req, group2_req, ev, clr, d;
   logic [5:0]                      timer_flags;
   logic [2:0]                      gate_flags, gate_prio;
   logic [1:0]                      capcomp_flags, capcomp_prio, e;
   logic [7:0]                      sh [10];
   integer                          seed, num_errors, total_checks, cycles, k;

   periph_flag_model i_periph_flag_model (.sys_clk(sys_clk), .reset(reset),
      .event_pulse(ev), .flag_clear(clr), .flags_q(serial_flags));

   periph_irq_enable_priority i_periph_irq_enable_priority (.sys_clk(sys_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .serial_flags(serial_flags),
      .timer_flags(timer_flags), .gate_flags(gate_flags), .capcomp_flags(capcomp_flags),
      .misc_flags(misc_flags), .group0_req(group0_req), .group1_req(group1_req),
      .group2_req(group2_req), .gate_prio(gate_prio), .capcomp_prio(capcomp_prio),
      .misc_prio(misc_prio), .irq_high(irq_high), .irq_low(irq_low));

   // ---------------------------------
   // expectations and bus tasks
   // ---------------------------------
   // bit 1 low request, bit 0 high request
   function automatic logic [1:0] part(input logic [7:0] s, en, pr);
      return {|(s & en & ~pr), |(s & en & pr)};
   endfunction

   // reserved misc bits fall out through the masked enable copy
   function automatic logic [1:0] route();
      return part(serial_flags, sh[0], sh[8]) | part({2'h0, timer_flags}, sh[1], sh[9])
         | part({5'h0, gate_flags}, sh[2], {5'h0, gate_prio})
         | part({6'h0, capcomp_flags}, sh[3], {6'h0, capcomp_prio})
         | part(misc_flags, sh[4], misc_prio) | part(group0_req, 8'h37, sh[5])
         | part(group1_req, 8'hc3, sh[6]) | part(group2_req, 8'hc3, sh[7]);
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_at(input logic [11:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_at(input logic [11:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic wr(input integer i, input logic [7:0] v);
      wr_at(irq_prio_pkg::REG_OFFSET[i], v);
      sh[i] = v & MSK[i];
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------
   // clock and hang guard
   // ---------------------------------
   always #5 sys_clk = ~sys_clk;

   // the whole run needs well under 5000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      seed = 32'h57a86f81;
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      {sys_clk, reg_write, reg_read, reg_addr, reg_wdata, ev, clr} = '0;
      {timer_flags, gate_flags, capcomp_flags, misc_flags, misc_prio} = '0;
      {group0_req, group1_req, group2_req, gate_prio, capcomp_prio} = '0;
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd_at(irq_prio_pkg::REG_OFFSET[i], d);
         chk("reset value", RST[i], d);
         sh[i] = RST[i];
      end
      // all ones, all zeros, then random patterns on every register
      for (int n = 0; n < 5; n++) begin
         for (int i = 0; i < 10; i++) begin
            wr(i, (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'($random(seed)));
            rd_at(irq_prio_pkg::REG_OFFSET[i], d);
            chk("readback", sh[i], d);
         end
      end
      @(posedge sys_clk);
      #1 chk("idle read data", 8'h00, reg_rdata);
      // unmapped places take nothing and read as zero
      wr_at(12'hfff, 8'hff);
      wr_at(12'h000, 8'hff);
      wr_at(irq_prio_pkg::STATUS_OFFSET, 8'hff);
      rd_at(12'hfff, d);
      chk("unmapped read", 8'h00, d);
      for (int i = 0; i < 10; i++) begin
         rd_at(irq_prio_pkg::REG_OFFSET[i], d);
         chk("untouched", sh[i], d);
      end
      // random sources, enables and priorities against the routing
      for (int n = 0; n < 400; n++) begin
         if ({$random(seed)} % 3 == 0) begin
            k = {$random(seed)} % 10;
            wr(k, 8'($random(seed)));
         end
         @(posedge sys_clk);
         ev <= 8'($random(seed) & $random(seed));
         clr <= 8'($random(seed) & $random(seed));
         {timer_flags, gate_flags, capcomp_flags, gate_prio, capcomp_prio} <= 16'($random(seed));
         {misc_flags, misc_prio, group0_req, group1_req} <= $random(seed);
         group2_req <= 8'($random(seed));
         @(posedge sys_clk);
         ev <= 8'h00;
         clr <= 8'h00;
         @(posedge sys_clk);
         #1 e = route();
         chk("high request", {7'h0, e[0]}, {7'h0, irq_high});
         chk("low request", {7'h0, e[1]}, {7'h0, irq_low});
         rd_at(irq_prio_pkg::STATUS_OFFSET, d);
         chk("status", {6'h00, e}, d);
      end
      // a second reset in mid-run must restore every register
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      #1 chk("request in reset", 8'h00, {6'h00, irq_high, irq_low});
      chk("read data in reset", 8'h00, reg_rdata);
      for (int i = 0; i < 10; i++) begin
         rd_at(irq_prio_pkg::REG_OFFSET[i], d);
         chk("reset again", RST[i], d);
      end
      wrap_up();
   end
endmodule // periph_irq_enable_priority_bench
`default_nettype wire
